// *** src/amfrm_top.sv ***
// Fault protection and restart sequencer for a two-channel class-D stage.
// Assumes detector flags and mode pin are asynchronous levels, one clock.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps

module amfrm_top
  import amfrm_pkg::*;
#(
  parameter int FAULT_INDICATOR_PIN_REL_C = amfrm_pkg::FAULT_INDICATOR_PIN_REL_CYC,
  parameter int MUTE_RET_C = amfrm_pkg::MUTE_RET_CYC,
  parameter int OPER_RET_C = amfrm_pkg::OPER_RET_CYC,
  parameter int SETTLE_C = amfrm_pkg::SETTLE_CYC,
  parameter int SUP_RESTART_C = amfrm_pkg::SUP_RESTART_CYC,
  parameter int GAIN_STEP_C = amfrm_pkg::GAIN_STEP_CYC,
  parameter int OC_LIMIT_C = amfrm_pkg::OC_LIMIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [amfrm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] mode_pin,
  input wire logic cur_limit_pin,
  input wire logic fold_lo_pin,
  input wire logic fold_hi_pin,
  input wire logic over_temp_pin,
  input wire logic window_short_pin,
  input wire logic low_supply_pin,
  input wire logic high_supply_pin,
  input wire logic imbalance_pin,
  input wire logic fault_indicator_pin_i,
  output logic fault_indicator_pin_o,
  output logic fault_indicator_pin_oe,
  output logic stage_en,
  output logic audio_en,
  output logic [amfrm_pkg::GAIN_W-1:0] gain_rolloff,
  output logic irq
);
  import amfrm_pkg::*;

  // ==========================================================
  // Parameter checks
  // ==========================================================
  if (FAULT_INDICATOR_PIN_REL_C < 1 || FAULT_INDICATOR_PIN_REL_C >= MUTE_RET_C || MUTE_RET_C >= OPER_RET_C
      || OPER_RET_C >= (1 << CNT_W) - 1 || SETTLE_C >= (1 << CNT_W) - 1
      || SUP_RESTART_C >= (1 << CNT_W) - 1 || SETTLE_C < 1
      || SUP_RESTART_C < 1) begin : g_bad_delay
    $error("amfrm_top: delay parameters out of order or range");
  end
  if (OC_LIMIT_C < 1 || OC_LIMIT_C >= (1 << OC_W) || GAIN_STEP_C < 1
      || GAIN_STEP_C >= (1 << CNT_W)) begin : g_bad_misc
    $error("amfrm_top: limit or step parameter out of range");
  end

  localparam logic [CNT_W-1:0] FAULT_INDICATOR_PIN_C = CNT_W'(FAULT_INDICATOR_PIN_REL_C);
  localparam logic [CNT_W-1:0] MUTE_C = CNT_W'(MUTE_RET_C);
  localparam logic [CNT_W-1:0] OPER_C = CNT_W'(OPER_RET_C);
  localparam logic [CNT_W-1:0] SETL_C = CNT_W'(SETTLE_C);
  localparam logic [CNT_W-1:0] SUPR_C = CNT_W'(SUP_RESTART_C);
  localparam logic [CNT_W-1:0] GSTEP_C = CNT_W'(GAIN_STEP_C - 1);
  localparam logic [OC_W-1:0] OCL_C = OC_W'(OC_LIMIT_C);
  localparam int SYN_W = 11; // Synchronised input count

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [SYN_W-1:0] raw_in; // Asynchronous pin levels
  logic [SYN_W-1:0] sync1_ff; // First stage, read only by second
  logic [SYN_W-1:0] sync2_ff; // Safe levels
  logic [SYN_W-1:0] dly_ff; // Previous safe level, for edges
  logic [1:0] mode_s; // Requested mode
  logic cl_s, flo_s, fhi_s, ot_s, win_s, lv_s, hv_s, ub_s, fault_indicator_pin_s;

  assign raw_in = {mode_pin, cur_limit_pin, fold_lo_pin, fold_hi_pin, over_temp_pin,
                   window_short_pin, low_supply_pin, high_supply_pin, imbalance_pin,
                   fault_indicator_pin_i};
  assign {mode_s, cl_s, flo_s, fhi_s, ot_s, win_s, lv_s, hv_s, ub_s, fault_indicator_pin_s} = sync2_ff;

  // Two flops per pin; the mode pin is a slow RC level so bus skew is harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      dly_ff <= '0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      dly_ff <= sync2_ff;
    end
  end

  // ==========================================================
  // Registers seen by software
  // ==========================================================
  logic ctrl_hold_ff, nxt_ctrl_hold; // Software forced standby
  logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat; // Sticky events
  logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask; // Event enables
  logic irq_ff, nxt_irq;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [IRQ_W-1:0] events; // One-cycle fault events
  logic [31:0] status_word; // Live state view
  logic addr_ok, setup_ph, access_ph;

  // ==========================================================
  // Sequencer state
  // ==========================================================
  amfrm_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt; // Shared delay counter
  logic [OC_W-1:0] oc_cnt_ff, nxt_oc_cnt; // Limiting persistence
  logic stby_req, oper_req, oc_trip;

  assign stby_req = (mode_s == MODE_STBY) || ctrl_hold_ff;
  assign oper_req = !stby_req && (mode_s != MODE_MUTE);
  assign oc_trip = (oc_cnt_ff == OCL_C);

  // Next state: mode handling, timed restarts, then fault overrides
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STBY: begin
        // Any wake request goes through the window test first
        if (!stby_req) nxt_state = ST_WIN;
      end
      ST_WIN: begin
        // Start-up halts here while an output sits on a rail
        if (!win_s) nxt_state = ST_MUTE;
      end
      ST_MUTE: begin
        if (oper_req) nxt_state = ST_SETTLE;
      end
      ST_SETTLE: begin
        // Input coupling caps charge before audio is let through
        if (!oper_req) nxt_state = ST_MUTE;
        else if (cnt_ff >= SETL_C) nxt_state = ST_OPER;
      end
      ST_OPER: begin
        if (!oper_req) nxt_state = ST_MUTE;
        else if (oc_trip) nxt_state = ST_OC;
      end
      ST_OC: begin
        // Window check at the return to mute spots a rail short
        if (cnt_ff >= MUTE_C && win_s) nxt_state = ST_RAIL;
        else if (cnt_ff >= OPER_C) nxt_state = oper_req ? ST_OPER : ST_MUTE;
      end
      ST_RAIL: begin
        if (!win_s) nxt_state = ST_WIN;
      end
      ST_OT: begin
        if (!ot_s) nxt_state = ST_WIN;
      end
      ST_HV: begin
        // No restart delay here, unlike the other supply faults
        if (!hv_s) nxt_state = ST_WIN;
      end
      ST_SUP: begin
        if (cnt_ff >= SUPR_C) nxt_state = ST_WIN;
      end
      default: begin
        nxt_state = ST_STBY;
      end
    endcase
    // Fault overrides, most severe first
    if (stby_req) nxt_state = ST_STBY;
    else if (ot_s) nxt_state = ST_OT;
    else if (hv_s) nxt_state = ST_HV;
    else if (lv_s || ub_s) nxt_state = ST_SUP;
  end

  // Delay counter: zero on every state change, held at zero while supply bad
  always_comb begin
    if (nxt_state != state_ff || (state_ff == ST_SUP && (lv_s || ub_s))) begin
      nxt_cnt = '0;
    end else if (cnt_ff == {CNT_W{1'b1}}) begin
      nxt_cnt = cnt_ff; // Saturate, never wrap back into a window
    end else begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
    // Limiting is tolerated until it persists for the full limit time
    if (state_ff == ST_OPER && cl_s && !oc_trip) begin
      nxt_oc_cnt = oc_cnt_ff + OC_W'(1);
    end else if (state_ff == ST_OPER && cl_s) begin
      nxt_oc_cnt = oc_cnt_ff;
    end else begin
      nxt_oc_cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_STBY;
      cnt_ff <= '0;
      oc_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      oc_cnt_ff <= nxt_oc_cnt;
    end
  end

  // ==========================================================
  // Power stage, mute and pin outputs
  // ==========================================================
  logic stage_ff, nxt_stage, audio_ff, nxt_audio, fault_indicator_pin_oe_ff, nxt_fault_indicator_pin_oe;
  logic [GAIN_W-1:0] gain_ff, nxt_gain; // Thermal attenuation level
  logic [CNT_W-1:0] gstep_ff, nxt_gstep; // Gain step timer

  // Decode of next state so outputs line up with state_ff
  always_comb begin
    nxt_stage = 1'b0;
    nxt_audio = 1'b0;
    nxt_fault_indicator_pin_oe = 1'b0;
    case (nxt_state)
      ST_MUTE, ST_SETTLE: nxt_stage = 1'b1;
      ST_OPER: begin
        nxt_stage = 1'b1;
        nxt_audio = 1'b1;
        nxt_fault_indicator_pin_oe = cl_s; // Limiting made visible on the pin
      end
      ST_OC: begin
        // Off for the first part, idle switching in the mute part
        nxt_stage = (nxt_cnt >= MUTE_C);
        nxt_fault_indicator_pin_oe = (nxt_cnt < FAULT_INDICATOR_PIN_C);
      end
      ST_RAIL: nxt_fault_indicator_pin_oe = 1'b1;
      default: begin
        // Standby, window test and supply or thermal faults: all off
        nxt_stage = 1'b0;
      end
    endcase
  end

  // Thermal roll-off: ramps while warm, full mute at the upper flag
  always_comb begin
    nxt_gstep = (gstep_ff >= GSTEP_C) ? '0 : gstep_ff + CNT_W'(1);
    nxt_gain = gain_ff;
    if (fhi_s) begin
      nxt_gain = GAIN_MAX;
    end else if (gstep_ff >= GSTEP_C) begin
      if (flo_s && gain_ff != GAIN_MAX) nxt_gain = gain_ff + GAIN_W'(1);
      else if (!flo_s && gain_ff != '0) nxt_gain = gain_ff - GAIN_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_ff <= 1'b0;
      audio_ff <= 1'b0;
      fault_indicator_pin_oe_ff <= 1'b0;
      gain_ff <= '0;
      gstep_ff <= '0;
    end else begin
      stage_ff <= nxt_stage;
      audio_ff <= nxt_audio;
      fault_indicator_pin_oe_ff <= nxt_fault_indicator_pin_oe;
      gain_ff <= nxt_gain;
      gstep_ff <= nxt_gstep;
    end
  end

  assign stage_en = stage_ff;
  assign audio_en = audio_ff;
  assign gain_rolloff = gain_ff;
  assign fault_indicator_pin_o = 1'b0; // Open drain: only ever pulls low
  assign fault_indicator_pin_oe = fault_indicator_pin_oe_ff;

  // ==========================================================
  // APB slave and interrupt logic
  // ==========================================================
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
                   || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK);
  assign pready = 1'b1; // Read data already captured in setup
  assign pslverr = access_ph && !addr_ok;
  assign prdata = prdata_ff;

  // Rising edges of fault flags and the overcurrent trip itself
  assign events[IRQ_OC] = (state_ff == ST_OPER) && (nxt_state == ST_OC);
  assign events[IRQ_WIN] = win_s && !dly_ff[4];
  assign events[IRQ_OT] = ot_s && !dly_ff[5];
  assign events[IRQ_LV] = lv_s && !dly_ff[3];
  assign events[IRQ_HV] = hv_s && !dly_ff[2];
  assign events[IRQ_UB] = ub_s && !dly_ff[1];

  always_comb begin
    status_word = RST_WORD;
    status_word[ST_STATE_LSB +: 4] = state_ff;
    status_word[ST_STAGE_BIT] = stage_ff;
    status_word[ST_AUDIO_BIT] = audio_ff;
    status_word[ST_GAIN_LSB +: GAIN_W] = gain_ff;
    status_word[ST_FAULT_INDICATOR_PIN_BIT] = fault_indicator_pin_s;
    status_word[ST_CLIM_BIT] = cl_s;
  end

  // Register writes, read capture and read-to-clear
  always_comb begin
    nxt_ctrl_hold = ctrl_hold_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_prdata = prdata_ff;
    // Clear only what was captured, so a later event is not lost
    nxt_irq_stat = irq_stat_ff;
    if (access_ph && !pwrite && paddr == ADDR_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~prdata_ff[IRQ_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | events; // Set wins over clear
    if (access_ph && pwrite) begin
      if (paddr == ADDR_CTRL) nxt_ctrl_hold = pwdata[CTRL_HOLD_BIT];
      if (paddr == ADDR_IRQ_MASK) nxt_irq_mask = pwdata[IRQ_W-1:0];
    end
    if (setup_ph && !pwrite) begin
      case (paddr)
        ADDR_CTRL: nxt_prdata = {31'h0000_0000, ctrl_hold_ff};
        ADDR_STATUS: nxt_prdata = status_word;
        ADDR_IRQ_STAT: nxt_prdata = {26'h000_0000, irq_stat_ff};
        ADDR_IRQ_MASK: nxt_prdata = {26'h000_0000, irq_mask_ff};
        default: nxt_prdata = RST_WORD; // Unmapped reads as zero
      endcase
    end
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_hold_ff <= 1'b0;
      irq_mask_ff <= '0;
      irq_stat_ff <= '0;
      prdata_ff <= RST_WORD;
      irq_ff <= 1'b0;
    end else begin
      ctrl_hold_ff <= nxt_ctrl_hold;
      irq_mask_ff <= nxt_irq_mask;
      irq_stat_ff <= nxt_irq_stat;
      prdata_ff <= nxt_prdata;
      irq_ff <= nxt_irq;
    end
  end

  assign irq = irq_ff;

  // ==========================================================
  // Assertions
  // ==========================================================
  logic no_fault;
  assign no_fault = !stby_req && !ot_s && !hv_s && !lv_s && !ub_s;

  sequence s_limiting;
    state_ff == ST_OPER && cl_s && !oc_trip && oper_req && no_fault;
  endsequence
  sequence s_trip;
    state_ff == ST_OPER && oc_trip && oper_req && no_fault;
  endsequence

  a_limit_keeps_on: assert property (@(posedge pclk) disable iff (!presetn)
    s_limiting |=> stage_en && state_ff == ST_OPER)
    else $error("stage stopped during tolerated current limiting");
  a_trip_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
    s_trip |=> state_ff == ST_OC && !stage_en && fault_indicator_pin_oe)
    else $error("overcurrent trip did not shut the stage down");
  a_restart_off: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_OC && cnt_ff < MUTE_C |-> !stage_en)
    else $error("stage on before the restart point");
  a_restart_order: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_OC && cnt_ff >= FAULT_INDICATOR_PIN_C |-> !fault_indicator_pin_oe
    && (stage_en == (cnt_ff >= MUTE_C)) && !audio_en)
    else $error("restart release, mute and operate out of order");
  a_rail_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_RAIL |-> fault_indicator_pin_oe && !stage_en)
    else $error("rail short hold not kept");
  a_window_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_WIN && win_s && no_fault |=> state_ff == ST_WIN && !stage_en)
    else $error("stage enabled while output shorted to a rail");
  a_fold_mute: assert property (@(posedge pclk) disable iff (!presetn)
    fhi_s |=> gain_rolloff == GAIN_MAX)
    else $error("upper thermal flag did not fully mute");
  a_overtemp_off: assert property (@(posedge pclk) disable iff (!presetn)
    ot_s && !stby_req |=> !stage_en && state_ff == ST_OT)
    else $error("overtemperature did not disable the stage");
  a_supply_delay: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_SUP && cnt_ff < SUPR_C |-> !stage_en && !fault_indicator_pin_oe)
    else $error("supply restart delay not kept");
  a_hv_resume: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_HV && !hv_s && no_fault |=> state_ff == ST_WIN)
    else $error("high supply recovery was delayed");
  a_imbalance_off: assert property (@(posedge pclk) disable iff (!presetn)
    ub_s && !stby_req && !ot_s && !hv_s |=> state_ff == ST_SUP ##1 !stage_en)
    else $error("supply imbalance did not switch off");
  a_settle_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_ff == ST_OPER) |-> $past(state_ff) inside {ST_SETTLE, ST_OC})
    else $error("operating entered without the mute dwell");
  a_pin_only_oc: assert property (@(posedge pclk) disable iff (!presetn)
    fault_indicator_pin_oe |-> state_ff inside {ST_OPER, ST_OC, ST_RAIL})
    else $error("indicator pin driven for a non-current fault");
  a_cnt_zeroed: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff != $past(state_ff) |-> cnt_ff == '0)
    else $error("delay counter not restarted on state change");
  a_standby_off: assert property (@(posedge pclk) disable iff (!presetn)
    stby_req |=> state_ff == ST_STBY ##1 !stage_en)
    else $error("standby request did not turn stages off");

endmodule // amfrm_top

// *** pkg/amfrm_pkg.sv ***
// Constants and types for the amplifier fault and restart manager.
// Assumes a single 20 MHz clock and an APB slave with 32-bit data.
package amfrm_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_HZ = 20_000_000; // Internal clock rate
  localparam int CLK_NS = 50; // Clock period in ns
  localparam int MS_CYC = CLK_HZ / 1000; // Cycles per millisecond
  localparam int FAULT_INDICATOR_PIN_REL_MS = 50; // Pin released after switch-off
  localparam int MUTE_RET_MS = 100; // Back to mute after switch-off
  localparam int OPER_RET_MS = 150; // Back to operation after switch-off
  localparam int SETTLE_MS = 150; // Mute dwell before operating
  localparam int SUP_RESTART_MS = 100; // Delay after supply recovers
  localparam int GAIN_STEP_MS = 1; // Thermal gain step interval
  localparam int FAULT_INDICATOR_PIN_REL_CYC = FAULT_INDICATOR_PIN_REL_MS * MS_CYC;
  localparam int MUTE_RET_CYC = MUTE_RET_MS * MS_CYC;
  localparam int OPER_RET_CYC = OPER_RET_MS * MS_CYC;
  localparam int SETTLE_CYC = SETTLE_MS * MS_CYC;
  localparam int SUP_RESTART_CYC = SUP_RESTART_MS * MS_CYC;
  localparam int GAIN_STEP_CYC = GAIN_STEP_MS * MS_CYC;
  // Current-limit persistence before trip (sense cap discharge time)
  localparam int OC_LIMIT_NS = 10_000;
  localparam int OC_LIMIT_CYC = (OC_LIMIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 22; // Delay counter width
  localparam int OC_W = 12; // Current-limit counter width

  // ==========================================================
  // Mode pin encoding (after the RC comparators)
  // ==========================================================
  localparam logic [1:0] MODE_STBY = 2'h0;
  localparam logic [1:0] MODE_MUTE = 2'h1;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000; // Control
  localparam logic [11:0] ADDR_STATUS = 12'h004; // Live status
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008; // Sticky events
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c; // Event enables
  localparam int CTRL_HOLD_BIT = 0; // Force standby
  localparam int ST_STATE_LSB = 0; // State code, 4 bits
  localparam int ST_STAGE_BIT = 4;
  localparam int ST_AUDIO_BIT = 5;
  localparam int ST_GAIN_LSB = 6; // Gain attenuation, 4 bits
  localparam int ST_FAULT_INDICATOR_PIN_BIT = 10; // Pin level read back
  localparam int ST_CLIM_BIT = 11; // Current limiting now
  localparam int IRQ_OC = 0;
  localparam int IRQ_WIN = 1;
  localparam int IRQ_OT = 2;
  localparam int IRQ_LV = 3;
  localparam int IRQ_HV = 4;
  localparam int IRQ_UB = 5;
  localparam int IRQ_W = 6;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int GAIN_W = 4;
  localparam logic [3:0] GAIN_MAX = 4'hf; // Full output mute

  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [3:0] {
    ST_STBY, ST_WIN, ST_MUTE, ST_SETTLE, ST_OPER,
    ST_OC, ST_RAIL, ST_OT, ST_HV, ST_SUP
  } amfrm_state_t;

endpackage

// *** sim/amfrm_far_side.sv ***
// Far side model: mode RC network and the fault pin read-out circuit.
// Assumes the bench sets the settled mode level and the design's pin drive.
`timescale 1ns/1ps

module amfrm_far_side (
  input wire logic [1:0] mode_req,
  output logic [1:0] mode_pin,
  input wire logic ind_o,
  input wire logic ind_oe,
  output logic ind_level
);
  // ==========================================================
  // Mode pin
  // ==========================================================
  // RC ramp is taken as settled, the comparators see a clean level
  assign mode_pin = mode_req;
  // ==========================================================
  // Fault pin read-out
  // ==========================================================
  // Level shifter pulls a released pin high, never a stale value
  assign ind_level = ind_oe ? ind_o : 1'b1;
endmodule // amfrm_far_side

// *** sim/test_amfrm_top.sv ***
// Self-checking bench for the fault and restart sequencer.
// Assumes shortened delay parameters and a 0-wait-state APB slave.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end

module test_amfrm_top;
  import amfrm_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam int DREL = 50, MRET = 100, ORET = 150, SETL = 150, SUPR = 100;
  localparam logic [1:0] MODE_RUN = 2'h2; // Operate request
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic cl = 0, flo = 0, fhi = 0, ot = 0, ws = 0, lv = 0, hv = 0, ub = 0, er;
  logic [1:0] mode_req = MODE_STBY, mode_pin;
  logic ind_i, ind_o, ind_oe, stage_en, audio_en, irq;
  logic [3:0] gain;
  int fail_count = 0, tests_run = 0;
  // One 50 ns clock for the single amplifier instance
  always #25 pclk = ~pclk;
  amfrm_far_side far (.mode_req(mode_req), .mode_pin(mode_pin), .ind_o(ind_o),
    .ind_oe(ind_oe), .ind_level(ind_i));
  amfrm_top #(.FAULT_INDICATOR_PIN_REL_C(DREL), .MUTE_RET_C(MRET), .OPER_RET_C(ORET), .SETTLE_C(SETL),
    .SUP_RESTART_C(SUPR), .GAIN_STEP_C(4), .OC_LIMIT_C(8)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_pin(mode_pin), .cur_limit_pin(cl), .fold_lo_pin(flo), .fold_hi_pin(fhi),
    .over_temp_pin(ot), .window_short_pin(ws), .low_supply_pin(lv),
    .high_supply_pin(hv), .imbalance_pin(ub), .fault_indicator_pin_i(ind_i),
    .fault_indicator_pin_o(ind_o), .fault_indicator_pin_oe(ind_oe),
    .stage_en(stage_en), .audio_en(audio_en), .gain_rolloff(gain), .irq(irq));
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task cyc(input int n); repeat (n) @(posedge pclk); endtask
  // Holds the request until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait for pready
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Bounded wait for the stage enable to reach a level
  task wait_stage(input logic v, input int lim);
    int n;
    n = 0;
    while (stage_en !== v && n < lim) begin @(posedge pclk); n++; end
    `CHK(stage_en, v)
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task t_start;
    @(posedge pclk); ws <= 1; mode_req <= MODE_MUTE;
    cyc(20); `CHK(stage_en, 1'b0)
    ws <= 0; wait_stage(1, 10); `CHK(audio_en, 1'b0)
    mode_req <= MODE_RUN; cyc(SETL - 5); `CHK(audio_en, 1'b0)
    cyc(15); `CHK(audio_en, 1'b1)
  endtask
  task t_limit;
    apb(1, ADDR_IRQ_MASK, 32'h0000_0001);
    cl <= 1; cyc(4); cl <= 0; cyc(20); `CHK(stage_en, 1'b1)
    cl <= 1; wait_stage(0, 30); `CHK(ind_oe, 1'b1)
    `CHK(irq, 1'b1)
    apb(0, ADDR_IRQ_STAT, 0); `CHK(rd[IRQ_OC], 1'b1)
    cyc(2); `CHK(irq, 1'b0)
    cyc(DREL - 12); `CHK(ind_oe, 1'b1)
    cyc(10); `CHK(ind_oe, 1'b0)
    cyc(MRET - DREL - 10); `CHK(stage_en, 1'b0)
    cyc(10); `CHK(stage_en, 1'b1)
    wait_stage(0, ORET); `CHK(ind_oe, 1'b1)
    cl <= 0; cyc(ORET - 10); `CHK(audio_en, 1'b0)
    cyc(20); `CHK(audio_en, 1'b1)
  endtask
  task t_rail;
    @(posedge pclk); cl <= 1; ws <= 1;
    wait_stage(0, 30); cl <= 0; cyc(MRET + 30);
    `CHK(stage_en, 1'b0)
    `CHK(ind_i, 1'b0)
    ws <= 0; wait_stage(1, 20); `CHK(ind_oe, 1'b0)
  endtask
  task t_supply;
    apb(1, ADDR_IRQ_MASK, 0);
    for (int i = 0; i < 4; i++) begin
      {ub, lv, hv, ot} <= 4'b0001 << i;
      cyc(4); `CHK(stage_en, 1'b0)
      `CHK(ind_oe, 1'b0)
      `CHK(irq, 1'b0)
      {ub, lv, hv, ot} <= 4'b0000;
      if (i >= 2) begin cyc(SUPR - 10); `CHK(stage_en, 1'b0) end
      wait_stage(1, i >= 2 ? 30 : 8);
    end
    apb(1, ADDR_IRQ_MASK, 32'h0000_0004); cyc(2); `CHK(irq, 1'b1)
    apb(0, ADDR_IRQ_STAT, 0); `CHK(rd[5:2], 4'hf)
    `CHK(rd[IRQ_WIN], 1'b1)
    `CHK(er, 1'b0)
    cyc(2); `CHK(irq, 1'b0)
  endtask
  task t_fold;
    @(posedge pclk); flo <= 1; cyc(12);
    `CHK(gain != 4'h0 && gain != GAIN_MAX, 1'b1)
    fhi <= 1; cyc(80); `CHK(gain, GAIN_MAX)
    `CHK(stage_en, 1'b1)
    apb(0, 12'h010, 0); `CHK(er, 1'b1)
    apb(1, ADDR_CTRL, 32'h0000_0001); cyc(3); `CHK(stage_en, 1'b0)
    apb(0, ADDR_STATUS, 0); `CHK(rd[ST_STATE_LSB +: 4], 4'h0)
    `CHK(rd[ST_FAULT_INDICATOR_PIN_BIT], 1'b1)
  endtask
  // ==========================================================
  // Verdict, watchdog and main sequence
  // ==========================================================
  task test_done;
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin cyc(20000); fail_count++; test_done; end
  initial begin
    cyc(3); presetn <= 1;
    t_start; t_limit; t_rail; t_supply; t_fold;
    test_done;
  end
endmodule // test_amfrm_top
